// ### rtl/mba_map.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module mba_map #(
  parameter mba_pkg::mba_variant_t VARIANT = mba_pkg::VAR_8K
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // program counter control from the core
  input  wire logic                          pc_step,
  input  wire logic                          pc_jump,
  input  wire logic [mba_pkg::LIT_W-1:0]     pc_jump_lit,
  input  wire logic                          irq_take,
  // data register port
  input  wire logic [mba_pkg::OFF_W-1:0]     reg_addr,
  input  wire logic [mba_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [mba_pkg::DATA_W-1:0]    reg_rdata_ff,
  // program fetch address
  output logic      [mba_pkg::PC_W-1:0]      prog_addr_ff,
  // core register state
  output logic      [mba_pkg::DATA_W-1:0]    core_status_ff,
  output logic      [mba_pkg::DATA_W-1:0]    indirect_pointer_ff,
  output logic      [1:0]                    bank_sel_ff,
  // last access landed on no implemented location
  output logic                               unimpl_access_ff
);
  import mba_pkg::*;

  // ---------------------------------------------------------------
  // decode of a full 9-bit data address
  // ---------------------------------------------------------------
  function automatic mba_hit_t decode_addr(
    input logic [DADDR_W-1:0] a,
    input mba_variant_t       v
  );
    logic [1:0]       bk;
    logic [OFF_W-1:0] off;
    mba_hit_t         h;
    logic             ram_b0;
    logic             ram_b1;
    logic             ram_b2_narrow;
    logic             ram_b2_wide;
    logic             ram_b3_wide;
    bk     = a[DADDR_W-1:OFF_W];
    off    = a[OFF_W-1:0];
    // ram windows per bank; smaller variants leave holes that read as zero
    ram_b0        = bk == 2'h0 && off >= GPR_LO_OFF;
    ram_b1        = bk == 2'h1 && off >= GPR_LO_OFF
                    && (v != VAR_2K || off <= BANK1_2K_END);
    ram_b2_narrow = bk == 2'h2 && v == VAR_4K
                    && off >= GPR_LO_OFF && off <= BANK2_4K_END;
    ram_b2_wide   = bk == 2'h2 && v == VAR_8K && off >= GPR_WIDE_LO_OFF;
    ram_b3_wide   = bk == 2'h3 && v == VAR_8K && off >= GPR_WIDE_LO_OFF;
    h.kind = K_NONE;
    h.idx  = '0;
    if (off == OFF_INDIRECT_PORT) begin
      h.kind = K_INDIRECT_ACCESS_PORT;
    end else if (off == OFF_PC_LOW_BYTE) begin
      h.kind = K_PCL;
    end else if (off == OFF_CORE_STATUS) begin
      h.kind = K_STATUS;
    end else if (off == OFF_IND_POINTER) begin
      h.kind = K_FSR;
    end else if (off == OFF_PC_HIGH_LATCH) begin
      h.kind = K_PCH;
    end else if (off >= COMMON_LO_OFF) begin
      h.kind = K_GPR;
      h.idx  = GPR_IDX_W'(off - GPR_LO_OFF);
    end else if (ram_b0) begin
      h.kind = K_GPR;
      h.idx  = GPR_IDX_W'(off - GPR_LO_OFF);
    end else if (ram_b1) begin
      h.kind = K_GPR;
      h.idx  = BANK1_BASE + GPR_IDX_W'(off - GPR_LO_OFF);
    end else if (ram_b2_narrow) begin
      h.kind = K_GPR;
      h.idx  = BANK2_BASE + GPR_IDX_W'(off - GPR_LO_OFF);
    end else if (ram_b2_wide) begin
      h.kind = K_GPR;
      h.idx  = BANK2_BASE + GPR_IDX_W'(off - GPR_WIDE_LO_OFF);
    end else if (ram_b3_wide) begin
      h.kind = K_GPR;
      h.idx  = BANK3_BASE + GPR_IDX_W'(off - GPR_WIDE_LO_OFF);
    end
    return h;
  endfunction

  // program space mask for the chosen variant
  function automatic logic [PC_W-1:0] prog_mask(input mba_variant_t v);
    logic [PC_W-1:0] m;
    m = PROG_MASK_8K;
    if (v == VAR_2K) begin
      m = PROG_MASK_2K;
    end else if (v == VAR_4K) begin
      m = PROG_MASK_4K;
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PC_W-1:0]   pc_ff;
  logic [4:0]        pc_high_latch_ff;

  mba_ram_if ram_bus ();

  // ---------------------------------------------------------------
  // address formation
  // ---------------------------------------------------------------
  wire [1:0] bank_sel;
  wire       bank_select_low;
  wire       bank_select_high;

  assign bank_select_low  = core_status_ff[STATUS_BANK_LO_BIT];
  assign bank_select_high = core_status_ff[STATUS_BANK_HI_BIT];
  assign bank_sel         = {bank_select_high, bank_select_low};

  wire [DADDR_W-1:0] direct_addr;
  wire [DADDR_W-1:0] indirect_addr;
  wire               via_pointer;
  wire [DADDR_W-1:0] eff_addr;

  // indirect address takes its bank bit from status bit 7
  assign direct_addr   = {bank_sel, reg_addr};
  assign indirect_addr = {core_status_ff[STATUS_IND_BANK_BIT],
                          indirect_pointer_ff};
  assign via_pointer   = (reg_addr == OFF_INDIRECT_PORT);
  assign eff_addr      = via_pointer ? indirect_addr : direct_addr;

  mba_hit_t hit;
  assign hit = decode_addr(eff_addr, VARIANT);

  // pointer aimed back at the indirect port reaches nothing
  wire [2:0] kind_bits;
  wire       hit_none;
  wire       hit_gpr;
  wire       hit_pcl;
  wire       hit_status;
  wire       hit_fsr;
  wire       hit_pch;

  assign kind_bits  = hit.kind;
  assign hit_gpr    = kind_bits == K_GPR;
  assign hit_pcl    = kind_bits == K_PCL;
  assign hit_status = kind_bits == K_STATUS;
  assign hit_fsr    = kind_bits == K_FSR;
  assign hit_pch    = kind_bits == K_PCH;
  assign hit_none   = kind_bits == K_NONE || kind_bits == K_INDIRECT_ACCESS_PORT;

  // ---------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------
  wire       wr_gpr;
  wire       wr_pcl;
  wire       wr_status;
  wire       wr_fsr;
  wire       wr_pch;
  wire [4:0] hit_vec;
  wire [4:0] wr_vec;

  assign hit_vec = {hit_pch, hit_fsr, hit_status, hit_pcl, hit_gpr};

  // one strobe per writable target
  for (genvar gi = 0; gi < 5; gi++) begin : g_wr_strobe
    assign wr_vec[gi] = reg_wr && hit_vec[gi];
  end

  assign wr_gpr    = wr_vec[0];
  assign wr_pcl    = wr_vec[1];
  assign wr_status = wr_vec[2];
  assign wr_fsr    = wr_vec[3];
  assign wr_pch    = wr_vec[4];

  // ---------------------------------------------------------------
  // general ram
  // ---------------------------------------------------------------
  // ram contents are not reset; a read before any write is unknown
  assign ram_bus.we    = wr_gpr;
  assign ram_bus.idx   = hit.idx;
  assign ram_bus.wdata = reg_wdata;

  mba_gpr_ram u_gpr_ram (
    .core_clk (core_clk),
    .ram      (ram_bus.mem)
  );

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] rd_gpr;
  wire [DATA_W-1:0] rd_pcl;
  wire [DATA_W-1:0] rd_pch;
  wire [DATA_W-1:0] rd_status;
  wire [DATA_W-1:0] rd_fsr;
  wire [DATA_W-1:0] rd_sel;
  wire [DATA_W-1:0] nxt_reg_rdata;

  assign rd_gpr = hit_gpr ? ram_bus.rdata : '0;
  assign rd_pcl = hit_pcl ? pc_ff[DATA_W-1:0] : '0;
  assign rd_pch    = hit_pch ? {3'h0, pc_high_latch_ff} : '0;
  assign rd_status = hit_status ? core_status_ff : '0;
  assign rd_fsr    = hit_fsr ? indirect_pointer_ff : '0;
  // nothing hit leaves every term at zero
  assign rd_sel = rd_gpr
                | rd_pcl
                | rd_pch
                | rd_status
                | rd_fsr;
  assign nxt_reg_rdata = reg_rd ? rd_sel : '0;

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  wire [PC_W-1:0] pcl_load;
  wire [PC_W-1:0] jump_load;
  wire [PC_W-1:0] pc_inc;
  wire [PC_W-1:0] nxt_pc;
  wire [PC_W-1:0] nxt_prog_addr;
  wire [PC_W-1:0] space_mask;

  assign pcl_load  = {pc_high_latch_ff, reg_wdata};
  assign jump_load = {pc_high_latch_ff[4:3], pc_jump_lit};
  assign pc_inc    = pc_ff + PC_W'(1);

  // interrupt first, then software load, then branch, then step
  assign nxt_pc = irq_take ? PC_IRQ_VEC :
                  wr_pcl   ? pcl_load   :
                  pc_jump  ? jump_load  :
                  pc_step  ? pc_inc     :
                             pc_ff;

  // pc keeps all 13 bits; only the fetch address is cut to the space
  assign space_mask    = prog_mask(VARIANT);
  assign nxt_prog_addr = nxt_pc & space_mask;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_ff <= PC_RESET_VEC;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prog_addr_ff <= PC_RESET_VEC;
    end else begin
      prog_addr_ff <= nxt_prog_addr;
    end
  end

  // ---------------------------------------------------------------
  // core registers
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] nxt_core_status;
  wire [DATA_W-1:0] nxt_indirect_pointer;
  wire [4:0]        nxt_pc_high_latch;

  assign nxt_core_status      = wr_status ? reg_wdata : core_status_ff;
  assign nxt_indirect_pointer = wr_fsr ? reg_wdata : indirect_pointer_ff;
  assign nxt_pc_high_latch    = wr_pch ? reg_wdata[4:0] : pc_high_latch_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_status_ff <= CORE_STATUS_RST;
    end else begin
      core_status_ff <= nxt_core_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      indirect_pointer_ff <= IND_POINTER_RST;
    end else begin
      indirect_pointer_ff <= nxt_indirect_pointer;
    end
  end

  // pc high latch keeps five bits; upper three read as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_high_latch_ff <= PC_HIGH_RST;
    end else begin
      pc_high_latch_ff <= nxt_pc_high_latch;
    end
  end

  // bank view follows status after the write lands
  wire [1:0] nxt_bank_sel;
  assign nxt_bank_sel = {nxt_core_status[STATUS_BANK_HI_BIT],
                         nxt_core_status[STATUS_BANK_LO_BIT]};

  // ---------------------------------------------------------------
  // read data and access flag
  // ---------------------------------------------------------------
  wire any_access;
  wire nxt_unimpl;
  assign any_access = reg_rd || reg_wr;
  assign nxt_unimpl = any_access && hit_none;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bank_sel_ff <= '0;
    end else begin
      bank_sel_ff <= nxt_bank_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      unimpl_access_ff <= 1'b0;
    end else begin
      unimpl_access_ff <= nxt_unimpl;
    end
  end

endmodule // mba_map

// ### inc/mba_pkg.sv
package mba_pkg;

  // widths
  localparam int PC_W      = 13;
  localparam int OFF_W     = 7;
  localparam int DADDR_W   = 9;
  localparam int DATA_W    = 8;
  localparam int LIT_W     = 11;
  localparam int GPR_DEPTH = 368;
  localparam int GPR_IDX_W = 9;

  // program memory vectors and wrap masks
  localparam logic [PC_W-1:0] PC_RESET_VEC = 13'h0000;
  localparam logic [PC_W-1:0] PC_IRQ_VEC   = 13'h0004;
  localparam logic [PC_W-1:0] PROG_MASK_2K = 13'h07FF;
  localparam logic [PC_W-1:0] PROG_MASK_4K = 13'h0FFF;
  localparam logic [PC_W-1:0] PROG_MASK_8K = 13'h1FFF;

  // core register offsets, mirrored in every bank
  localparam logic [OFF_W-1:0] OFF_INDIRECT_PORT = 7'h00;
  localparam logic [OFF_W-1:0] OFF_PC_LOW_BYTE   = 7'h02;
  localparam logic [OFF_W-1:0] OFF_CORE_STATUS   = 7'h03;
  localparam logic [OFF_W-1:0] OFF_IND_POINTER   = 7'h04;
  localparam logic [OFF_W-1:0] OFF_PC_HIGH_LATCH = 7'h0A;

  // core_status field positions
  localparam int STATUS_BANK_LO_BIT = 5;
  localparam int STATUS_BANK_HI_BIT = 6;
  localparam int STATUS_IND_BANK_BIT = 7;

  // reset values
  localparam logic [DATA_W-1:0] CORE_STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] IND_POINTER_RST = 8'h00;
  localparam logic [4:0]        PC_HIGH_RST     = 5'h00;

  // general ram layout within a bank
  localparam logic [OFF_W-1:0] GPR_LO_OFF      = 7'h20;
  localparam logic [OFF_W-1:0] GPR_WIDE_LO_OFF = 7'h10;
  localparam logic [OFF_W-1:0] COMMON_LO_OFF   = 7'h70;
  localparam logic [OFF_W-1:0] BANK1_2K_END    = 7'h3F;
  localparam logic [OFF_W-1:0] BANK2_4K_END    = 7'h2F;
  localparam logic [GPR_IDX_W-1:0] BANK1_BASE  = 9'h060;
  localparam logic [GPR_IDX_W-1:0] BANK2_BASE  = 9'h0B0;
  localparam logic [GPR_IDX_W-1:0] BANK3_BASE  = 9'h110;

  typedef enum logic [1:0] {
    VAR_2K = 2'b00,
    VAR_4K = 2'b01,
    VAR_8K = 2'b10
  } mba_variant_t;

  typedef enum logic [2:0] {
    K_NONE   = 3'b000,
    K_GPR    = 3'b001,
    K_INDIRECT_ACCESS_PORT   = 3'b010,
    K_PCL    = 3'b011,
    K_STATUS = 3'b100,
    K_FSR    = 3'b101,
    K_PCH    = 3'b110
  } mba_kind_t;

  typedef struct packed {
    mba_kind_t            kind;
    logic [GPR_IDX_W-1:0] idx;
  } mba_hit_t;

endpackage

// ### inc/mba_ram_if.sv
`timescale 1ns/1ps
interface mba_ram_if;
  logic                          we;
  logic [mba_pkg::GPR_IDX_W-1:0] idx;
  logic [mba_pkg::DATA_W-1:0]    wdata;
  logic [mba_pkg::DATA_W-1:0]    rdata;

  modport ctrl (
    output we,
    output idx,
    output wdata,
    input  rdata
  );

  modport mem (
    input  we,
    input  idx,
    input  wdata,
    output rdata
  );
endinterface

// ### rtl/mba_gpr_ram.sv
`timescale 1ns/1ps
module mba_gpr_ram (
  // clock
  input wire logic core_clk,
  // storage port
  mba_ram_if.mem   ram
);
  import mba_pkg::*;

  logic [DATA_W-1:0] mem_ff [GPR_DEPTH];

  wire in_range = ram.idx < GPR_IDX_W'(GPR_DEPTH);

  always_ff @(posedge core_clk) begin
    if (ram.we && in_range) begin
      mem_ff[ram.idx] <= ram.wdata;
    end
  end

  assign ram.rdata = in_range ? mem_ff[ram.idx] : '0;

endmodule // mba_gpr_ram

// ### bench/mba_core_model.sv
`timescale 1ns/1ps
module mba_core_model (
  // command from the bench, {irq, jump, step}
  input  wire logic [2:0]                cmd,
  input  wire logic [mba_pkg::LIT_W-1:0] lit,
  // program counter control
  output logic                           pc_step,
  output logic                           pc_jump,
  output logic [mba_pkg::LIT_W-1:0]      pc_jump_lit,
  output logic                           irq_take
);
  import mba_pkg::*;
  assign pc_step     = cmd[0];
  assign pc_jump     = cmd[1];
  assign pc_jump_lit = lit;
  assign irq_take    = cmd[2];
endmodule // mba_core_model

// ### bench/mba_map_props.sv
`timescale 1ns/1ps
module mba_map_props #(
  parameter mba_pkg::mba_variant_t VARIANT = mba_pkg::VAR_8K
) (
  // watched ports
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic                       pc_step,
  input wire logic                       pc_jump,
  input wire logic [mba_pkg::LIT_W-1:0]  pc_jump_lit,
  input wire logic                       irq_take,
  input wire logic [mba_pkg::OFF_W-1:0]  reg_addr,
  input wire logic [mba_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [mba_pkg::DATA_W-1:0] reg_rdata_ff,
  input wire logic [mba_pkg::PC_W-1:0]   prog_addr_ff,
  input wire logic [mba_pkg::DATA_W-1:0] core_status_ff,
  input wire logic [mba_pkg::DATA_W-1:0] indirect_pointer_ff,
  input wire logic [1:0]                 bank_sel_ff,
  input wire logic                       unimpl_access_ff
);
  import mba_pkg::*;
  localparam logic [PC_W-1:0] MASK = (VARIANT == VAR_2K) ? PROG_MASK_2K :
                                     (VARIANT == VAR_4K) ? PROG_MASK_4K : PROG_MASK_8K;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_RESET_VEC: assert property ($fell(rst) |-> prog_addr_ff == PC_RESET_VEC
    && core_status_ff == 8'h00 && indirect_pointer_ff == 8'h00) else $error("bad reset state");
  AST_IRQ_VEC: assert property (irq_take |=> prog_addr_ff == (PC_IRQ_VEC & MASK))
    else $error("interrupt vector not loaded");
  AST_STEP: assert property (pc_step && !pc_jump && !irq_take && !reg_wr
    |=> prog_addr_ff == (($past(prog_addr_ff) + 13'h0001) & MASK)) else $error("bad step");
  AST_JUMP: assert property (pc_jump && !irq_take && !reg_wr
    |=> prog_addr_ff[10:0] == ($past(pc_jump_lit) & MASK[10:0])) else $error("bad jump");
  AST_WRAP: assert property ((prog_addr_ff & ~MASK) == 13'h0000)
    else $error("fetch address outside space");
  AST_BANK: assert property (bank_sel_ff == core_status_ff[6:5])
    else $error("bank select differs from status");
  AST_STATUS_WR: assert property (reg_wr && reg_addr == OFF_CORE_STATUS
    |=> core_status_ff == $past(reg_wdata)) else $error("status write lost");
  AST_PTR_WR: assert property (reg_wr && reg_addr == OFF_IND_POINTER
    |=> indirect_pointer_ff == $past(reg_wdata)) else $error("pointer write lost");
  AST_PTR_RD: assert property (reg_rd && reg_addr == OFF_IND_POINTER
    |=> reg_rdata_ff == $past(indirect_pointer_ff)) else $error("pointer read wrong");
  AST_UNIMPL: assert property ((reg_rd || reg_wr) && reg_addr == 7'h01
    |=> unimpl_access_ff && reg_rdata_ff == 8'h00) else $error("hole not flagged");
  AST_IDLE: assert property (!reg_rd && !reg_wr |=> !unimpl_access_ff
    && reg_rdata_ff == 8'h00) else $error("output without access");
  cover property (irq_take && reg_wr);
  cover property (reg_rd && reg_addr == OFF_INDIRECT_PORT);
  cover property (pc_jump && pc_step);
endmodule // mba_map_props
bind mba_map mba_map_props #(.VARIANT(VARIANT)) mba_map_props_i (.core_clk, .rst, .pc_step,
  .pc_jump, .pc_jump_lit, .irq_take, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
  .prog_addr_ff, .core_status_ff, .indirect_pointer_ff, .bank_sel_ff, .unimpl_access_ff);

// ### bench/test_mba_map.sv
`timescale 1ns/1ps
module test_mba_map;
  import mba_pkg::*;
  typedef struct {int due; logic [15:0] v; logic [7:0] s; logic [7:0] p;} mba_note_t;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [2:0]        cmd = 3'h0;
  logic [2:0]        ci = 3'h0;
  logic [LIT_W-1:0]  lit = 11'h000;
  logic [LIT_W-1:0]  pc_jump_lit;
  logic              pc_step, pc_jump, irq_take, unimpl_access_ff;
  logic [OFF_W-1:0]  reg_addr = 7'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata_ff, core_status_ff, indirect_pointer_ff;
  logic [DATA_W-1:0] st = 8'h00;
  logic [DATA_W-1:0] ptr = 8'h00;
  logic [PC_W-1:0]   prog_addr_ff, prog2_ff;
  logic [PC_W-1:0]   pc = 13'h0000;
  logic [1:0]        bank_sel_ff;
  logic [6:0]        offs [6] = '{7'h10, 7'h1f, 7'h20, 7'h6f, 7'h70, 7'h7f};
  mba_note_t         reg_q[$];
  mba_note_t         pc_q[$];
  logic [DATA_W-1:0] mem[int];
  logic [31:0]       r;
  int                cyc = 0;
  int                err_count = 0;
  int                check_count = 0;
  int                seed = 32'hafb6;

  always #2 core_clk = ~core_clk;
  mba_core_model mba_core_model_i (.cmd, .lit, .pc_step, .pc_jump, .pc_jump_lit, .irq_take);
  mba_map mba_map_i (.core_clk, .rst, .pc_step, .pc_jump, .pc_jump_lit, .irq_take, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .prog_addr_ff, .core_status_ff,
    .indirect_pointer_ff, .bank_sel_ff, .unimpl_access_ff);
  mba_map #(.VARIANT(VAR_2K)) mba_map_v2k_i (.core_clk, .rst, .pc_step, .pc_jump, .pc_jump_lit,
    .irq_take, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff(),
    .prog_addr_ff(prog2_ff), .core_status_ff(), .indirect_pointer_ff(), .bank_sel_ff(),
    .unimpl_access_ff());

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_pc(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: fetch address got %h expected %h", $time, got, exp);
    end
  endtask

  // model map: -1 for no storage, else key of the physical location
  function automatic int phys(input logic [8:0] a);
    if (a[6:0] == 7'h00) return -1;
    if (a[6:0] inside {7'h02, 7'h03, 7'h04, 7'h0a} || a[6:0] >= 7'h70) return int'(a[6:0]);
    if (a[8:7] == 2'b00 ? a[6:0] >= 7'h20
        : a[6:0] < 7'h70 && a[6:0] >= (a[8:7] == 2'b01 ? 7'h20 : 7'h10)) return int'(a);
    return -1;
  endfunction

  task automatic note_pc();
    pc_q.push_back('{cyc + 1, {3'h0, pc}, 8'h00, 8'h00});
  endtask

  task automatic pcmd(input logic [2:0] c, input logic [LIT_W-1:0] l);
    cmd <= c;
    lit <= l;
    ci = c;
    if (c[2]) pc = PC_IRQ_VEC;
    else if (c[1]) pc = {mem[10][4:3], l};
    else if (c[0]) pc = pc + 13'h0001;
    if (c != 3'h0) note_pc();
  endtask

  task automatic pc_go(input logic [2:0] c, input logic [LIT_W-1:0] l);
    pcmd(c, l);
    @(posedge core_clk);
  endtask

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic op(input logic [6:0] off, input logic wr, input logic [7:0] d);
    logic [8:0] a;
    int k;
    a = (off == 7'h00) ? {st[7], ptr} : {st[6:5], off};
    k = phys(a);
    if (k >= 0 && !mem.exists(k)) wr = 1'b1;
    reg_addr <= off;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    if (wr && k == 2) begin
      if (!ci[2]) pc = {mem[10][4:0], d};
      if (ci != 3'h0) void'(pc_q.pop_back());
      note_pc();
    end
    if (wr && k >= 0) mem[k] = (k == 10) ? (d & 8'h1f) : d;
    if (wr && k == 3) st = d;
    if (wr && k == 4) ptr = d;
    reg_q.push_back('{cyc + 1, {6'h00, !wr, k < 0,
      (wr || k < 0) ? 8'h00 : (k == 2 ? pc[7:0] : mem[k])}, st, ptr});
    @(posedge core_clk);
    ci = 3'h0;
  endtask

  always @(negedge core_clk) begin
    if (reg_q.size() > 0 && reg_q[0].due == cyc) begin
      cmp_reg({7'h00, unimpl_access_ff}, {7'h00, reg_q[0].v[8]}, "hole flag");
      if (reg_q[0].v[9]) cmp_reg(reg_rdata_ff, reg_q[0].v[7:0], "read");
      cmp_reg(core_status_ff, reg_q[0].s, "status");
      cmp_reg({6'h00, bank_sel_ff}, {6'h00, reg_q[0].s[6:5]}, "bank");
      cmp_reg(indirect_pointer_ff, reg_q[0].p, "pointer");
      void'(reg_q.pop_front());
    end
    if (pc_q.size() > 0 && pc_q[0].due == cyc) begin
      cmp_pc(prog_addr_ff, pc_q[0].v[12:0] & PROG_MASK_8K);
      cmp_pc(prog2_ff, pc_q[0].v[12:0] & PROG_MASK_2K);
      void'(pc_q.pop_front());
    end
    cyc <= cyc + 1;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    stop_test();
  end

  initial begin
    mem[2] = 8'h00;
    mem[3] = 8'h00;
    mem[4] = 8'h00;
    mem[10] = 8'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    op(7'h03, 1'b0, 8'h00);
    op(7'h04, 1'b0, 8'h00);
    op(7'h0a, 1'b0, 8'h00);
    op(7'h01, 1'b1, 8'hff);
    op(7'h01, 1'b0, 8'h00);
    idle();
    repeat (3) pc_go(3'h1, 11'h000);
    pc_go(3'h4, 11'h000);
    pc_go(3'h0, 11'h000);
    op(7'h0a, 1'b1, 8'hf8);
    idle();
    pc_go(3'h2, 11'h7ff);
    pc_go(3'h1, 11'h000);
    pc_go(3'h3, 11'h123);
    pcmd(3'h4, 11'h000);
    op(7'h02, 1'b1, 8'h34);
    pcmd(3'h0, 11'h000);
    op(7'h02, 1'b1, 8'h56);
    op(7'h02, 1'b0, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 4; b++) begin
        op(7'h03, 1'b1, {1'b0, b[1:0], 5'h00});
        foreach (offs[j]) op(offs[j], p == 0, {b[1:0], j[5:0]});
        op(7'h04, p == 0, {6'h00, b[1:0]});
      end
    end
    op(7'h04, 1'b1, 8'h00);
    op(7'h00, 1'b1, 8'h5a);
    op(7'h00, 1'b0, 8'h00);
    op(7'h03, 1'b1, 8'h80);
    op(7'h04, 1'b1, 8'h90);
    op(7'h00, 1'b1, 8'ha5);
    op(7'h03, 1'b1, 8'h60);
    op(7'h10, 1'b0, 8'h00);
    op(7'h00, 1'b0, 8'h00);
    repeat (400) begin
      r = $random(seed);
      op(r[6:0], r[7], r[15:8]);
    end
    idle();
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule // test_mba_map
